//--- hw/aas_pkg.sv
/*
 * Constants, register map and state type of the converter acquisition sequencer.
 * Assumes a 32-bit AXI4-Lite register bus and one 250 MHz system clock.
 */
`default_nettype none
package aas_pkg;
	// Register byte offsets on the bus, one aligned word each.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
	localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
	// Control word fields.
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_FLAG_BIT = 1;
	localparam int CTRL_CHAN_LSB = 4;
	localparam int CHAN_W = 4;
	// Configuration word fields.
	localparam int CFG_CLK_LSB = 0;
	localparam int CFG_ACQ_LSB = 3;
	localparam int CFG_FMT_BIT = 7;
	localparam int SEL_W = 3;
	localparam logic [SEL_W-1:0] ACQ_SEL_RESET = 3'h0;
	localparam logic [SEL_W-1:0] CLK_SEL_RESET = 3'h0;
	localparam logic [SEL_W-1:0] ACQ_SEL_MANUAL = 3'h0;
	// Converter figures.
	localparam int RES_W = 10;
	localparam logic [3:0] CONV_TADS = 4'hb;
	localparam logic [1:0] GAP_TADS = 2'h2;
	localparam logic [2:0] INSTR_CYCLE_CLKS = 3'h4;
	localparam logic [5:0] DIV_MASK_FULL = 6'h3f;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sequencer states.
	typedef enum logic [2:0] {ST_SAMPLE, ST_ACQ, ST_RC_DELAY, ST_CONV, ST_GAP} aas_state_t;

	// Acquisition length in bit periods for each selection code.
	function automatic logic [4:0] acq_tads(input logic [SEL_W-1:0] sel);
		case (sel)
			3'h1: acq_tads = 5'h02;
			3'h2: acq_tads = 5'h04;
			3'h3: acq_tads = 5'h06;
			3'h4: acq_tads = 5'h08;
			3'h5: acq_tads = 5'h0c;
			3'h6: acq_tads = 5'h10;
			3'h7: acq_tads = 5'h14;
			default: acq_tads = 5'h00;
		endcase
	endfunction
endpackage
`default_nettype wire

//--- hw/aas_tick_if.sv
/*
 * Link between the sequencer and its bit-clock generator.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface aas_tick_if;
	logic restart; // Realigns the divider so a full bit period follows.
	logic [2:0] sel; // Conversion clock selection.
	logic tick; // One-cycle pulse at the end of every bit period.
	modport src (input restart, input sel, output tick);
	modport user (output restart, output sel, input tick);
endinterface
`default_nettype wire

//--- hw/aas_bit_clock.sv
/*
 * Bit-clock generator: divides the system clock or follows the internal RC clock.
 * Assumes the RC clock pin is asynchronous and far slower than clk.
 */
`timescale 1ns/1ps
`default_nettype none
module aas_bit_clock (
	input wire logic clk,
	input wire logic reset,
	input wire logic internal_rc_clock,
	aas_tick_if.src tk
);
	import aas_pkg::*;

	logic [5:0] div_cnt; // Free-running divider count.
	logic rc_s1, rc_s2, rc_s3; // Synchroniser pair and edge history.
	logic [5:0] mask; // Low bits that must all be set for a tick.
	logic [2:0] shift; // Log2 of the divide ratio.

	// Ratio codes 000..110 give 2,8,32 and with the top bit 4,16,64.
	always_comb begin
		shift = 3'(1 + 2 * tk.sel[1:0] + tk.sel[2]);
		mask = DIV_MASK_FULL >> (3'h6 - shift);
	end

	// The divider restarts so that each interval begins on a whole period.
	always_ff @(posedge clk) begin
		if (reset || tk.restart) begin
			div_cnt <= 6'h00;
		end else begin
			div_cnt <= div_cnt + 6'h01;
		end
	end

	// The RC pin passes two flops before the edge detector looks at it.
	always_ff @(posedge clk) begin
		if (reset) begin
			rc_s1 <= 1'b0;
			rc_s2 <= 1'b0;
			rc_s3 <= 1'b0;
		end else begin
			rc_s1 <= internal_rc_clock;
			rc_s2 <= rc_s1;
			rc_s3 <= rc_s2;
		end
	end

	// Selection x11 takes the RC clock; the others take the divider.
	// The tick never looks at restart, because restart is itself formed from the tick.
	always_comb begin
		if (tk.sel[1:0] == 2'h3) begin
			tk.tick = rc_s2 && !rc_s3;
		end else begin
			tk.tick = (div_cnt & mask) == mask;
		end
	end
endmodule
`default_nettype wire

//--- hw/aas_sequencer.sv
/*
 * Acquisition and conversion sequencer of a 10-bit successive-approximation converter,
 * with its AXI4-Lite register slave. Assumes the analog front end drives compare_in
 * high while the held input is at or above dac_code, from outside the clock domain.
 */
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module aas_sequencer (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic internal_rc_clock,
	input wire logic compare_in,
	output logic hold_capacitor,
	output logic [aas_pkg::RES_W-1:0] dac_code,
	output logic [aas_pkg::CHAN_W-1:0] chan_sel
);
	import aas_pkg::*;

	aas_tick_if tk (); // Bit-clock link.
	aas_state_t state; // Sequencer state.
	logic go; // Start flag, cleared by hardware at completion.
	logic conversion_complete_flag; // Sticky completion flag.
	logic [SEL_W-1:0] acq_time_sel; // Acquisition time selection.
	logic [SEL_W-1:0] conv_clk_sel; // Conversion clock selection.
	logic right_just; // Result alignment.
	logic [7:0] result_high, result_low; // Result byte pair.
	logic [4:0] acq_cnt; // Remaining acquisition periods.
	logic [3:0] tad_cnt; // Bit periods elapsed in conversion or gap.
	logic [2:0] dly_cnt; // Instruction-cycle delay count.
	logic [RES_W-1:0] sar; // Trial and result word.
	logic cmp_s1, cmp_s2; // Comparator synchroniser.
	logic aw_held, w_held; // Write channel halves already taken.
	logic [7:0] aw_addr; // Taken write address.
	logic [31:0] w_data; // Taken write data.
	logic [3:0] w_strb; // Taken write strobes.
	logic wr_fire; // Both halves present, response slot free.
	logic wr_ctrl, wr_cfg; // Register write decodes.
	logic start; // Start flag seen while sampling.
	logic begin_conv; // Conversion begins this cycle.
	logic done; // Last conversion period ends this cycle.
	logic [RES_W-1:0] sar_next; // Trial word after the current decision.

	aas_bit_clock u_bit_clock (
		.clk(clk),
		.reset(reset),
		.internal_rc_clock(internal_rc_clock),
		.tk(tk)
	);

	// Write channel: address and data are taken in either order.
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_ctrl = wr_fire && (aw_addr == ADDR_CTRL) && w_strb[0];
	assign wr_cfg = wr_fire && (aw_addr == ADDR_CFG) && w_strb[0];
	assign s_axi_arready = !s_axi_rvalid;

	// Both halves are held until the response slot is free.
	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Write response; unmapped offsets answer with a slave error.
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_CFG ||
				aw_addr == ADDR_RES_HIGH || aw_addr == ADDR_RES_LOW) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read path; only the start and completion flags show progress.
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0;
			case (s_axi_araddr)
				ADDR_CTRL: begin
					s_axi_rdata[CTRL_GO_BIT] <= go;
					s_axi_rdata[CTRL_FLAG_BIT] <= conversion_complete_flag;
					s_axi_rdata[CTRL_CHAN_LSB +: CHAN_W] <= chan_sel;
				end
				ADDR_CFG: begin
					s_axi_rdata[CFG_CLK_LSB +: SEL_W] <= conv_clk_sel;
					s_axi_rdata[CFG_ACQ_LSB +: SEL_W] <= acq_time_sel;
					s_axi_rdata[CFG_FMT_BIT] <= right_just;
				end
				ADDR_RES_HIGH: s_axi_rdata[7:0] <= result_high;
				ADDR_RES_LOW: s_axi_rdata[7:0] <= result_low;
				default: s_axi_rresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Configuration; the acquisition selection wakes in manual mode.
	always_ff @(posedge clk) begin
		if (reset) begin
			acq_time_sel <= ACQ_SEL_RESET;
			conv_clk_sel <= CLK_SEL_RESET;
			right_just <= 1'b0;
			chan_sel <= '0;
		end else begin
			if (wr_cfg) begin
				acq_time_sel <= w_data[CFG_ACQ_LSB +: SEL_W];
				conv_clk_sel <= w_data[CFG_CLK_LSB +: SEL_W];
				right_just <= w_data[CFG_FMT_BIT];
			end
			if (wr_ctrl) begin
				chan_sel <= w_data[CTRL_CHAN_LSB +: CHAN_W];
			end
		end
	end

	// Start flag: software sets it, completion clears it. Writing zero does not abort.
	always_ff @(posedge clk) begin
		if (reset) begin
			go <= 1'b0;
		end else if (done) begin
			go <= 1'b0;
		end else if (wr_ctrl && w_data[CTRL_GO_BIT]) begin
			go <= 1'b1;
		end
	end

	// Completion flag: a completion in the same cycle as a software clear wins.
	always_ff @(posedge clk) begin
		if (reset) begin
			conversion_complete_flag <= 1'b0;
		end else if (done) begin
			conversion_complete_flag <= 1'b1;
		end else if (wr_ctrl && !w_data[CTRL_FLAG_BIT]) begin
			conversion_complete_flag <= 1'b0;
		end
	end

	// Sequencing terms shared by the state machine and the divider.
	always_comb begin
		start = (state == ST_SAMPLE) && go;
		begin_conv = 1'b0;
		if (start && acq_time_sel == ACQ_SEL_MANUAL && conv_clk_sel[1:0] != 2'h3) begin
			begin_conv = 1'b1;
		end
		if (state == ST_ACQ && tk.tick && acq_cnt == 5'h01 && conv_clk_sel[1:0] != 2'h3) begin
			begin_conv = 1'b1;
		end
		if (state == ST_RC_DELAY && dly_cnt == 3'h1) begin
			begin_conv = 1'b1;
		end
		done = (state == ST_CONV) && tk.tick && (tad_cnt == CONV_TADS - 4'h1);
		tk.restart = begin_conv || (start && acq_time_sel != ACQ_SEL_MANUAL);
		tk.sel = conv_clk_sel;
	end

	// State machine: sample, optional timed acquisition, conversion, then a settling gap.
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_SAMPLE;
			acq_cnt <= 5'h00;
			dly_cnt <= 3'h0;
			tad_cnt <= 4'h0;
		end else begin
			case (state)
				ST_SAMPLE: begin
					if (start && acq_time_sel != ACQ_SEL_MANUAL) begin
						state <= ST_ACQ;
						acq_cnt <= acq_tads(acq_time_sel);
					end else if (start && conv_clk_sel[1:0] == 2'h3) begin
						state <= ST_RC_DELAY;
						dly_cnt <= INSTR_CYCLE_CLKS;
					end else if (start) begin
						state <= ST_CONV;
						tad_cnt <= 4'h0;
					end
				end
				ST_ACQ: begin
					if (tk.tick) begin
						acq_cnt <= acq_cnt - 5'h01;
						if (acq_cnt == 5'h01 && conv_clk_sel[1:0] == 2'h3) begin
							state <= ST_RC_DELAY;
							dly_cnt <= INSTR_CYCLE_CLKS;
						end else if (acq_cnt == 5'h01) begin
							state <= ST_CONV;
							tad_cnt <= 4'h0;
						end
					end
				end
				ST_RC_DELAY: begin
					dly_cnt <= dly_cnt - 3'h1;
					if (dly_cnt == 3'h1) begin
						state <= ST_CONV;
						tad_cnt <= 4'h0;
					end
				end
				ST_CONV: begin
					if (done) begin
						state <= ST_GAP;
						tad_cnt <= 4'h0;
					end else if (tk.tick) begin
						tad_cnt <= tad_cnt + 4'h1;
					end
				end
				ST_GAP: begin
					// The gap is not skipped even if software has already set start again.
					if (tk.tick && tad_cnt == {2'h0, GAP_TADS} - 4'h1) begin
						state <= ST_SAMPLE;
					end else if (tk.tick) begin
						tad_cnt <= tad_cnt + 4'h1;
					end
				end
				default: state <= ST_SAMPLE;
			endcase
		end
	end

	// The switch opens in the very cycle start is seen with no timed acquisition.
	assign hold_capacitor = (state == ST_SAMPLE && !(go && acq_time_sel == ACQ_SEL_MANUAL)) ||
		(state == ST_ACQ);

	// Comparator comes from the analog side and is synchronised first.
	// A decision is three clocks old, so divide by two leaves each trial too little time.
	always_ff @(posedge clk) begin
		if (reset) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
		end else begin
			cmp_s1 <= compare_in;
			cmp_s2 <= cmp_s1;
		end
	end

	// One decision per period for ten periods; the eleventh period closes out.
	always_comb begin
		sar_next = sar;
		if (tad_cnt < 4'(RES_W)) begin
			sar_next[RES_W - 1 - tad_cnt] = cmp_s2;
			if (tad_cnt < 4'(RES_W - 1)) begin
				sar_next[RES_W - 2 - tad_cnt] = 1'b1;
			end
		end
	end

	// Successive approximation register, seeded with the mid-scale trial.
	always_ff @(posedge clk) begin
		if (reset) begin
			sar <= '0;
		end else if (begin_conv || (state == ST_RC_DELAY && dly_cnt == INSTR_CYCLE_CLKS)) begin
			// The RC tick may come one clock after the start, so the seed goes out early.
			sar <= {1'b1, {(RES_W - 1){1'b0}}};
		end else if (state == ST_CONV && tk.tick) begin
			sar <= sar_next;
		end
	end
	assign dac_code = sar;

	// Result pair loads in the same cycle that start clears; aborted work never lands.
	always_ff @(posedge clk) begin
		if (reset) begin
			result_high <= 8'h00;
			result_low <= 8'h00;
		end else if (done && right_just) begin
			result_high <= {6'h00, sar[9:8]};
			result_low <= sar[7:0];
		end else if (done) begin
			result_high <= sar[9:2];
			result_low <= {sar[1:0], 6'h00};
		end
	end
endmodule
`default_nettype wire

//--- testbench/aas_sequencer_asserts.sv
/*
 * Port-level checker of the acquisition sequencer, bound to its top module.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module aas_sequencer_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic hold_capacitor,
	input wire logic [9:0] dac_code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [10:0] low_cnt; // Cycles the sampling switch has stayed open.
	// Saturating count of open-switch cycles, cleared while sampling.
	always_ff @(posedge clk) begin
		if (reset || hold_capacitor) begin
			low_cnt <= 11'h000;
		end else if (low_cnt != 11'h7ff) begin
			low_cnt <= low_cnt + 11'h001;
		end
	end
	a_reset_idle: assert property ($fell(reset) |-> hold_capacitor && s_axi_awready
		&& !s_axi_bvalid && !s_axi_rvalid) else $error("not idle after reset");
	a_open_min: assert property ($rose(hold_capacitor) |-> low_cnt >= 11'h018)
		else $error("switch reopened before conversion and gap ended");
	// A manual start set during the gap chains two conversions and gaps with no sampling.
	a_open_max: assert property (!hold_capacitor |-> low_cnt <= 11'h690)
		else $error("switch open too long");
	a_open_holds: assert property ($fell(hold_capacitor) |=> !hold_capacitor [*8])
		else $error("switch closed during conversion");
	a_dac_quiet: assert property ($changed(dac_code) && !$rose(hold_capacitor)
		|-> !hold_capacitor) else $error("trial word moved while sampling");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
endmodule
bind aas_sequencer aas_sequencer_asserts aas_sequencer_asserts_inst (.clk, .reset,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .hold_capacitor, .dac_code);
`default_nettype wire

//--- testbench/aas_front_model.sv
/*
 * Sample-and-hold front end, comparator and RC oscillator of the converter.
 * Assumes hold_capacitor high means the sampling switch is closed.
 */
`timescale 1ns/1ps
`default_nettype none
module aas_front_model (
	input wire logic clk,
	input wire logic [9:0] vin,
	input wire logic hold_capacitor,
	input wire logic [9:0] dac_code,
	output logic compare_in,
	output logic internal_rc_clock
);
	logic [9:0] held; // Voltage left on the capacitor.
	// The capacitor follows the input only while the switch is closed.
	always_ff @(posedge clk) begin
		if (hold_capacitor) begin
			held <= vin;
		end
	end
	// Comparator: high while the held input is at or above the trial word.
	assign compare_in = (held >= dac_code);
	// Free-running RC source, about ten system clocks, phase unrelated to clk.
	initial begin
		internal_rc_clock = 1'b0;
		#3.3;
		forever #19.7 internal_rc_clock = ~internal_rc_clock;
	end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
/*
 * Self-checking bench of the acquisition sequencer.
 * Assumes the front-end model and the checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import aas_pkg::*;
	typedef struct packed {logic [2:0] ck; logic [2:0] aq; logic fm; logic [9:0] v;} aas_row_t;
	logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic internal_rc_clock, compare_in, hold_capacitor;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, hi, lo;
	logic [3:0] s_axi_wstrb, chan_sel;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [9:0] dac_code, vin;
	int fail_count, n_checks, cyc, t_acq, t_low, n;
	int acqt [8] = '{0, 2, 4, 6, 8, 12, 16, 20}; // Periods per acquisition code.
	aas_row_t rows [8];
	aas_row_t r;
	aas_sequencer aas_sequencer_inst (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.internal_rc_clock, .compare_in, .hold_capacitor, .dac_code, .chan_sel);
	aas_front_model aas_front_model_inst (.clk, .vin, .hold_capacitor, .dac_code,
		.compare_in, .internal_rc_clock);
	// The system clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Cuts a hang short well past the longest expected run.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask
	// Bus write; each half is released at the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			pa = pa && !s_axi_awready;
			pw = pw && !s_axi_wready;
			@(posedge clk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		s_axi_bready <= 1'b1;
		do @(negedge clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		logic pa;
		pa = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (pa) begin
			@(negedge clk);
			pa = !s_axi_arready;
			@(posedge clk);
			s_axi_arvalid <= pa;
		end
		s_axi_rready <= 1'b1;
		do @(negedge clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask
	// Counts sampling cycles, then open-switch cycles, after a start.
	task automatic meas();
		t_acq = 0;
		t_low = 0;
		@(negedge clk);
		while (hold_capacitor === 1'b1) begin
			@(negedge clk);
			t_acq++;
		end
		while (hold_capacitor === 1'b0) begin
			@(negedge clk);
			t_low++;
		end
		@(posedge clk);
	endtask
	initial begin
		{reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, vin} = '0;
		s_axi_wstrb = 4'hf;
		{cyc, fail_count, n_checks} = '0;
		rows = '{{3'h0, 3'h0, 1'b0, 10'h3ff}, {3'h4, 3'h1, 1'b1, 10'h000},
			{3'h1, 3'h2, 1'b0, 10'h2a5}, {3'h5, 3'h3, 1'b1, 10'h15a},
			{3'h2, 3'h4, 1'b0, 10'h200}, {3'h6, 3'h5, 1'b1, 10'h1ff},
			{3'h3, 3'h6, 1'b0, 10'h0c3}, {3'h7, 3'h7, 1'b1, 10'h301}};
		@(posedge clk);
		do_reset();
		rdr(ADDR_CFG);
		chk("cfg", rd, 32'h0);
		// One conversion per row: every clock and acquisition code, both result formats.
		// A real driver picks the shortest legal period; the sweep covers every one.
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			n = 2 << (r.ck[2] + 2 * r.ck[1:0]);
			vin <= r.v;
			wr(ADDR_CFG, 32'(r.fm) << CFG_FMT_BIT | 32'(r.aq) << CFG_ACQ_LSB | 32'(r.ck));
			wr(ADDR_CTRL, 32'(i) << CTRL_CHAN_LSB);
			chk("chan", 32'(chan_sel), 32'(i));
			// Software lets the new channel settle before each start, timed or manual.
			repeat (40) @(posedge clk);
			wr(ADDR_CTRL, 32'(i) << CTRL_CHAN_LSB | 32'h1);
			meas();
			// Timing is exact only for the divided clock; the RC source is free-running.
			// The model never sleeps, so RC rows stand for a system clock under 1 MHz.
			if (r.ck[1:0] != 2'h3) begin
				chk("acq", 32'(t_acq + 3 >= acqt[r.aq] * n && t_acq <= acqt[r.aq] * n + 3), 1);
				chk("open", 32'(t_low + 3 >= 13 * n && t_low <= 13 * n + 3), 1);
			end
			rdr(ADDR_CTRL);
			chk("ctrl", rd, 32'(i) << CTRL_CHAN_LSB | 32'h2);
			hi = r.fm ? {30'h0, r.v[9:8]} : {24'h0, r.v[9:2]};
			lo = r.fm ? {24'h0, r.v[7:0]} : {24'h0, r.v[1:0], 6'h00};
			rdr(ADDR_RES_HIGH);
			chk("res_high", rd, hi);
			rdr(ADDR_RES_LOW);
			chk("res_low", rd, lo);
		end
		rdr(8'h10);
		chk("unmapped_rd", rd, 32'h0);
		chk("unmapped_rresp", 32'(rsp), 32'(RESP_SLVERR));
		wr(8'h10, 32'h1);
		chk("unmapped_wr", 32'(rsp), 32'(RESP_SLVERR));
		wr(ADDR_RES_HIGH, 32'hff);
		chk("ro_bresp", 32'(rsp), 32'(RESP_OKAY));
		rdr(ADDR_RES_HIGH);
		chk("res_ro", rd, hi);
		// A start written during the closing gap waits for it.
		wr(ADDR_CFG, 32'h6);
		wr(ADDR_CTRL, 32'h1);
		do rdr(ADDR_CTRL); while (rd[CTRL_GO_BIT] !== 1'b0);
		wr(ADDR_CTRL, 32'h1);
		meas();
		chk("gap", 32'(t_low + 24 >= 15 * 64 && t_low <= 15 * 64), 1);
		// Reset in mid-acquisition returns to manual, sampling, divide by two.
		wr(ADDR_CFG, 32'h3f);
		wr(ADDR_CTRL, 32'h1);
		repeat (20) @(posedge clk);
		do_reset();
		@(negedge clk);
		chk("hold_rst", 32'(hold_capacitor), 32'h1);
		@(posedge clk);
		rdr(ADDR_CFG);
		chk("cfg_rst", rd, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
